/* bdsr_delay.sv */
`timescale 1ns/1ps
`default_nettype none

// Counts a fixed number of cycles after a start pulse, then pulses done
module bdsr_delay #(
    parameter logic [7:0] COUNT = 8'h10
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control
    input wire logic start,
    output logic busy,
    output logic done
);

    logic [7:0] cnt; // Remaining cycles

    // A restart reloads the count, so only the last start counts
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (start) begin
            cnt <= COUNT - 8'h01;
            busy <= 1'b1;
            done <= 1'b0;
        end else if (busy && cnt == 8'h00) begin
            busy <= 1'b0;
            done <= 1'b1;
        end else begin
            if (busy) begin
                cnt <= cnt - 8'h01;
            end
            done <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* bdsr_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Debug host issuing one-cycle register commands
module bdsr_host (
    // Clock
    input wire logic clk,
    // Request to the register bank
    output var bdsr_pkg::bdsr_req_t req
);
    initial req = '0;
    // Idle shows inverted address and data so stale values never look valid
    task automatic access(input logic rd, input logic wr, input bdsr_pkg::bdsr_src_t src,
        input logic [15:0] addr, input logic [7:0] wdata);
        @(posedge clk);
        req <= '{rd, wr, src, addr, wdata};
        @(posedge clk);
        req <= '{1'b0, 1'b0, src, ~addr, ~wdata};
    endtask
endmodule
`default_nettype wire

/* bdsr_pkg.sv */
package bdsr_pkg;

    // Register addresses of the debug register window
    localparam logic [15:0] ADDR_RSVD0 = 16'hff00;
    localparam logic [15:0] ADDR_STATUS = 16'hff01;
    localparam logic [15:0] ADDR_CCR = 16'hff06;
    localparam logic [15:0] ADDR_POSITION = 16'hff07;
    localparam logic [15:0] ADDR_LAST = 16'hff0b;

    // Status register bit positions
    localparam int BIT_ENABLE = 7;
    localparam int BIT_ACTIVE = 6;
    localparam int BIT_TAGEN = 5;
    localparam int BIT_SDV = 4;
    localparam int BIT_TRACE = 3;
    localparam int BIT_CLKSEL = 2;
    localparam int BIT_UNSECURE_BIT = 1;

    // Position register field placement
    localparam int POS_LSB = 3;
    localparam int POS_MSB = 6;

    // Reset values
    localparam logic [7:0] CCR_RESET = 8'hd0;
    localparam logic [7:0] CCR_RESET_SSC = 8'hd8;

    // Timing counts
    localparam int TAG_DELAY_CYCLES = 16;
    localparam int DEBUG_CLOCK_SELECT_DELAY_CYCLES = 150;
    localparam int CNT_W = 8;

    // Who issues a register write
    typedef enum logic [1:0] {
        SRC_HW_CMD,
        SRC_FW_CMD,
        SRC_OTHER
    } bdsr_src_t;

    // One register access from the serial command engine
    typedef struct packed {
        logic rd;
        logic wr;
        bdsr_src_t src;
        logic [15:0] addr;
        logic [7:0] wdata;
    } bdsr_req_t;

    // Command engine events
    typedef struct packed {
        logic cmdRecv;
        logic isTrace;
        logic tag_and_go_command;
        logic bgEnter;
        logic bgExit;
        logic dataDone;
    } bdsr_evt_t;

endpackage

/* bdsr_regs.sv */
`timescale 1ns/1ps
`default_nettype none

// Function
// - registers reached only by debug read/write commands
// - decode status and saved-CCR as read/write
// - position register read-only, bits 14:11 at 6:3
// - active flag set on entry, firmware clears
// - clock select written only by debug commands
// - enable bit gates activation by bgRequest, not by the bgEnter event; hardware commands unaffected
// - enable set in special single-chip mode when unsecured or after erase-verify
// - active flag maps the firmware table
// - tag-enable set by tag-and-go, cleared on entry
// - serial off, tagging on seventeen cycles later
// - data-valid set on data, cleared next command
// - trace set on step command, cleared otherwise
// - unsecure reads one when secured and erased in special single-chip mode
// - enable reads one when unsecured or erased in special single-chip mode
// - new debug clock active after 150 cycles
module bdsr_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register access from the serial command engine
    input wire bdsr_pkg::bdsr_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic rdHit,
    // Command engine events
    input wire bdsr_pkg::bdsr_evt_t evt,
    input wire logic bgRequest,
    // Chip state
    input wire logic specialSingleChip,
    input wire logic secured,
    input wire logic eraseVerified,
    input wire logic [3:0] blockAddr,
    input wire logic [7:0] cpuCcr,
    // Tag pins (asynchronous, active low) and low-byte strobe enable (active high)
    input wire logic lowTagInputN,
    input wire logic highTagInputN,
    input wire logic lowByteStrobeEn,
    // Status outputs
    output logic debugEnable,
    output logic debugActive,
    output logic firmwareMapped,
    output logic serialEnabled,
    output logic taggingActive,
    output logic tagLow,
    output logic tagHigh,
    output logic debugClockSelect,
    output logic clockSwitching
);

    // Register state
    logic enableBit; // Debug enable
    logic activeFlag; // Background mode active
    logic tagEnableBit; // Tagging enable
    logic sdvBit; // Shift data valid
    logic traceBit; // Single-step in progress
    logic clkSelBit; // Debug clock select
    logic unsecBit; // Unsecured indication
    logic [7:0] savedCcr; // Saved condition codes
    logic sscSeen; // Reset-time strap caught after release
    logic [1:0] tagLoSync; // Pin synchronisers
    logic [1:0] tagHiSync;
    logic [1:0] sscSync;

    // Decode
    wire bdsr_pkg::bdsr_req_t r = req;
    wire logic cmdPath = (r.src == bdsr_pkg::SRC_HW_CMD) || (r.src == bdsr_pkg::SRC_FW_CMD);
    wire logic inWindow = (r.addr >= bdsr_pkg::ADDR_RSVD0) && (r.addr <= bdsr_pkg::ADDR_LAST);
    wire logic wrStatus = r.wr && cmdPath && (r.addr == bdsr_pkg::ADDR_STATUS);
    wire logic wrCcr = r.wr && cmdPath && (r.addr == bdsr_pkg::ADDR_CCR);
    wire logic fwWrite = wrStatus && (r.src == bdsr_pkg::SRC_FW_CMD);
    wire logic canActivate = enableBit && bgRequest && !activeFlag;
    wire logic enterBg = evt.bgEnter || canActivate;
    wire logic eraseOk = eraseVerified; // Secure check passed
    wire logic tagStart = evt.tag_and_go_command || (wrStatus && r.wdata[bdsr_pkg::BIT_TAGEN]);
    wire logic tagDone;
    wire logic tagBusy;
    wire logic clkBusy;
    wire logic clkChange = wrStatus && (r.wdata[bdsr_pkg::BIT_CLKSEL] != clkSelBit);

    // Reads: enable and unsecure reflect security in special single-chip mode
    wire logic enableRead = (sscSeen && (!secured || eraseOk)) ? 1'b1 : enableBit;
    wire logic unsecRead = sscSeen ? (secured && eraseOk) : unsecBit;
    wire logic [7:0] statusRead = {enableRead, activeFlag, tagEnableBit, sdvBit, traceBit,
                                   clkSelBit, unsecRead, 1'b0};
    wire logic [7:0] positionRead = {1'b0, blockAddr, 3'b000};
    wire logic [7:0] readMux = (r.addr == bdsr_pkg::ADDR_STATUS) ? statusRead :
                               (r.addr == bdsr_pkg::ADDR_CCR) ? savedCcr :
                               (r.addr == bdsr_pkg::ADDR_POSITION) ? positionRead : 8'h00;

    // Serial system off from the tag delay end until background entry
    bdsr_delay #(.COUNT(8'(bdsr_pkg::TAG_DELAY_CYCLES))) tagDelay (
        .clk(clk),
        .nrst(nrst),
        .start(tagStart),
        .busy(tagBusy),
        .done(tagDone)
    );

    // Clock-switch settle window
    bdsr_delay #(.COUNT(8'(bdsr_pkg::DEBUG_CLOCK_SELECT_DELAY_CYCLES))) clkDelay (
        .clk(clk),
        .nrst(nrst),
        .start(clkChange),
        .busy(clkBusy),
        .done()
    );

    // Pin and strap synchronisers, two stages each
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tagLoSync <= 2'b11;
            tagHiSync <= 2'b11;
            sscSync <= 2'b00;
        end else begin
            tagLoSync <= {tagLoSync[0], lowTagInputN};
            tagHiSync <= {tagHiSync[0], highTagInputN};
            sscSync <= {sscSync[0], specialSingleChip};
        end
    end

    // Mode strap held stable after reset, caught from the synchronised copy
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sscSeen <= 1'b0;
        end else begin
            sscSeen <= sscSync[1];
        end
    end

    // Enable and active flags
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            enableBit <= 1'b0;
            activeFlag <= 1'b0;
        end else begin
            if (sscSeen && (!secured || eraseOk)) begin
                enableBit <= 1'b1;
            end else if (wrStatus) begin
                enableBit <= r.wdata[bdsr_pkg::BIT_ENABLE];
            end
            // Entry wins over a same-cycle firmware clear
            if (enterBg) begin
                activeFlag <= 1'b1;
            end else if (fwWrite && !r.wdata[bdsr_pkg::BIT_ACTIVE]) begin
                activeFlag <= 1'b0;
            end
        end
    end

    // Tag enable, data valid, trace, clock select, unsecure
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tagEnableBit <= 1'b0;
            sdvBit <= 1'b0;
            traceBit <= 1'b0;
            clkSelBit <= 1'b0;
            unsecBit <= 1'b0;
        end else begin
            if (enterBg) begin
                tagEnableBit <= 1'b0;
            end else if (tagStart) begin
                tagEnableBit <= 1'b1;
            end
            // Data completion beats the clear from a new command
            if (evt.dataDone) begin
                sdvBit <= 1'b1;
            end else if (evt.cmdRecv || evt.bgExit) begin
                sdvBit <= 1'b0;
            end
            if (evt.cmdRecv) begin
                traceBit <= evt.isTrace;
            end
            if (wrStatus) begin
                clkSelBit <= r.wdata[bdsr_pkg::BIT_CLKSEL];
            end
            if (sscSeen && fwWrite) begin
                unsecBit <= r.wdata[bdsr_pkg::BIT_UNSECURE_BIT];
            end
        end
    end

    // Saved condition codes: captured on entry, writable by commands
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            savedCcr <= bdsr_pkg::CCR_RESET;
        end else if (enterBg) begin
            savedCcr <= cpuCcr;
        end else if (wrCcr) begin
            savedCcr <= r.wdata;
        end else if (!sscSeen && sscSync[1]) begin
            savedCcr <= bdsr_pkg::CCR_RESET_SSC;
        end
    end

    // Read data and registered status outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
            rdHit <= 1'b0;
            debugEnable <= 1'b0;
            debugActive <= 1'b0;
            firmwareMapped <= 1'b0;
            serialEnabled <= 1'b1;
            taggingActive <= 1'b0;
            tagLow <= 1'b0;
            tagHigh <= 1'b0;
            debugClockSelect <= 1'b0;
            clockSwitching <= 1'b0;
        end else begin
            rdata <= (r.rd && cmdPath) ? readMux : 8'h00;
            rvalid <= r.rd && cmdPath;
            rdHit <= r.rd && cmdPath && inWindow;
            debugEnable <= enableRead;
            debugActive <= activeFlag;
            firmwareMapped <= activeFlag;
            if (tagDone) begin
                serialEnabled <= 1'b0;
                taggingActive <= 1'b1;
            end else if (enterBg || !tagEnableBit) begin
                serialEnabled <= !tagBusy || enterBg;
                taggingActive <= 1'b0;
            end
            tagLow <= taggingActive && lowByteStrobeEn && !tagLoSync[1];
            tagHigh <= taggingActive && !tagHiSync[1];
            debugClockSelect <= clkSelBit;
            clockSwitching <= clkBusy;
        end
    end

endmodule

`default_nettype wire

/* bdsr_regs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level watcher of the debug register bank
module bdsr_regs_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Access and answer
    input wire bdsr_pkg::bdsr_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic rdHit,
    input wire bdsr_pkg::bdsr_evt_t evt,
    input wire logic [3:0] blockAddr,
    // Status
    input wire logic debugActive,
    input wire logic firmwareMapped,
    input wire logic serialEnabled,
    input wire logic taggingActive
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // Accepted sources and address classes
    wire okSrc = req.src != bdsr_pkg::SRC_OTHER;
    wire inWin = req.addr >= bdsr_pkg::ADDR_RSVD0 && req.addr <= bdsr_pkg::ADDR_LAST;
    wire isReg = req.addr inside {bdsr_pkg::ADDR_STATUS, bdsr_pkg::ADDR_CCR, bdsr_pkg::ADDR_POSITION};
    wire rsvd = inWin && !isReg;
    a_read_answer: assert property (req.rd && okSrc && serialEnabled |=> rvalid) else $error("read unanswered");
    a_other_ignored: assert property (req.rd && !okSrc |=> !rvalid) else $error("foreign read answered");
    a_idle_zero: assert property (!rvalid |-> rdata == 8'h00) else $error("rdata not zero when idle");
    a_hit_range: assert property (rvalid |-> rdHit == $past(inWin)) else $error("hit flag wrong");
    a_rsvd_zero: assert property (rvalid && $past(rsvd) |-> rdata == 8'h00) else $error("reserved read nonzero");
    a_pos_shadow: assert property (rvalid && $past(req.addr) == bdsr_pkg::ADDR_POSITION
        |-> rdata == {1'b0, $past(blockAddr), 3'b000}) else $error("position read wrong");
    a_tag_delay: assert property (evt.tag_and_go_command && serialEnabled
        |-> serialEnabled [*8] ##[10:12] (!serialEnabled && taggingActive)) else $error("tag delay wrong");
    a_map_active: assert property ($rose(debugActive) |-> ##[0:2] firmwareMapped) else $error("table not mapped");
    // Main scenarios
    c_tag: cover property (evt.tag_and_go_command);
    c_hit: cover property (rvalid && rdHit);
    c_active: cover property ($rose(debugActive));
endmodule
bind bdsr_regs bdsr_regs_monitor mon (.*);
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, nrst, bgRequest, ssc, secured, eraseVerified;
    logic lowTagN, highTagN, lowStrobe; // Tag pins driven by the host side
    wire logic tagLow, tagHigh, debugEnable, debugClockSelect, clockSwitching;
    logic [3:0] blockAddr;
    logic [7:0] cpuCcr, v;
    bdsr_pkg::bdsr_req_t req;
    bdsr_pkg::bdsr_evt_t evt;
    wire logic [7:0] rdata;
    wire logic rvalid, rdHit, debugActive, firmwareMapped, serialEnabled, taggingActive;
    int mismatches = 0;
    int n_checks = 0;
    // Tag pins idle high, pulled low only while tagging is checked
    bdsr_host host (.clk(clk), .req(req));
    bdsr_regs dut (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata), .rvalid(rvalid), .rdHit(rdHit),
        .evt(evt), .bgRequest(bgRequest), .specialSingleChip(ssc), .secured(secured),
        .eraseVerified(eraseVerified), .blockAddr(blockAddr), .cpuCcr(cpuCcr),
        .lowTagInputN(lowTagN), .highTagInputN(highTagN), .lowByteStrobeEn(lowStrobe),
        .debugEnable(debugEnable), .debugActive(debugActive), .firmwareMapped(firmwareMapped),
        .serialEnabled(serialEnabled), .taggingActive(taggingActive), .tagLow(tagLow), .tagHigh(tagHigh),
        .debugClockSelect(debugClockSelect), .clockSwitching(clockSwitching));
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        host.access(1'b1, 1'b0, bdsr_pkg::SRC_HW_CMD, a, 8'h00);
        @(negedge clk);
        check("rvalid", rvalid, 8'h01);
        d = rdata;
    endtask
    task automatic wr(input bdsr_pkg::bdsr_src_t s, input logic [15:0] a, input logic [7:0] d);
        host.access(1'b0, 1'b1, s, a, d);
    endtask
    task automatic pulse(input bdsr_pkg::bdsr_evt_t e);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= '0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic t_map();
        rd(16'hff06, v); check("ccr reset", v, bdsr_pkg::CCR_RESET);
        rd(16'hff01, v); check("status reset", v, 8'h00);
        wr(bdsr_pkg::SRC_HW_CMD, 16'hff07, 8'hff);
        rd(16'hff07, v); check("position", v, 8'h50);
        wr(bdsr_pkg::SRC_HW_CMD, 16'hff02, 8'hff);
        rd(16'hff02, v); check("reserved", v, 8'h00);
        wr(bdsr_pkg::SRC_FW_CMD, 16'hff06, 8'h5a);
        rd(16'hff06, v); check("ccr rw", v, 8'h5a);
        $display("test map done");
    endtask
    task automatic t_write();
        @(posedge clk);
        bgRequest <= 1'b1;
        repeat (4) @(posedge clk);
        bgRequest <= 1'b0;
        @(negedge clk);
        check("blocked", debugActive, 8'h00);
        wr(bdsr_pkg::SRC_OTHER, 16'hff01, 8'h84);
        rd(16'hff01, v); check("other write", v, 8'h00);
        wr(bdsr_pkg::SRC_HW_CMD, 16'hff01, 8'h84);
        rd(16'hff01, v); check("hw write", v, 8'h84);
        check("clk switching", clockSwitching, 8'h01);
        check("clk select", debugClockSelect, 8'h01);
        wr(bdsr_pkg::SRC_FW_CMD, 16'hff01, 8'h80);
        rd(16'hff01, v); check("fw write", v, 8'h80);
        // Switch window restarts on the second change and lasts 150 cycles
        repeat (140) @(posedge clk);
        @(negedge clk);
        check("clk settling", clockSwitching, 8'h01);
        repeat (12) @(posedge clk);
        @(negedge clk);
        check("clk settled", clockSwitching, 8'h00);
        check("clk select back", debugClockSelect, 8'h00);
        $display("test write done");
    endtask
    task automatic t_active();
        // Activation through the request line now that enable is set
        @(posedge clk);
        bgRequest <= 1'b1;
        @(posedge clk);
        bgRequest <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("active", debugActive, 8'h01);
        check("mapped", firmwareMapped, 8'h01);
        rd(16'hff06, v); check("ccr saved", v, 8'h3c);
        pulse(6'h30);
        pulse(6'h30);
        rd(16'hff01, v); check("trace", v, 8'hc8);
        pulse(6'h01);
        rd(16'hff01, v); check("sdv", v, 8'hd8);
        pulse(6'h02);
        rd(16'hff01, v); check("sdv exit", v, 8'hc8);
        pulse(6'h20);
        rd(16'hff01, v); check("cleared", v, 8'hc0);
        wr(bdsr_pkg::SRC_FW_CMD, 16'hff01, 8'h80);
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("unmapped", firmwareMapped, 8'h00);
        $display("test active done");
    endtask
    task automatic t_tag();
        @(posedge clk);
        evt <= 6'h08;
        @(posedge clk);
        evt <= '0;
        rd(16'hff01, v); check("tag bit", v, 8'ha0);
        check("serial on", serialEnabled, 8'h01);
        repeat (16) @(posedge clk);
        @(negedge clk);
        check("serial off", serialEnabled, 8'h00);
        check("tagging", taggingActive, 8'h01);
        // Host pulls both tag pins low; low tag needs the strobe enable
        @(posedge clk);
        highTagN <= 1'b0;
        lowTagN <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check("tag high", tagHigh, 8'h01);
        check("tag low gated", tagLow, 8'h00);
        @(posedge clk);
        lowStrobe <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("tag low", tagLow, 8'h01);
        @(posedge clk);
        highTagN <= 1'b1;
        lowTagN <= 1'b1;
        lowStrobe <= 1'b0;
        pulse(6'h04);
        rd(16'hff01, v); check("tag cleared", v, 8'hc0);
        $display("test tag done");
    endtask
    task automatic t_ssc();
        @(posedge clk);
        ssc <= 1'b1;
        secured <= 1'b1;
        eraseVerified <= 1'b1;
        do_reset();
        rd(16'hff01, v); check("unsecure_bit enable", v & 8'h82, 8'h82);
        check("enable pin", debugEnable, 8'h01);
        rd(16'hff06, v); check("ccr special", v, bdsr_pkg::CCR_RESET_SSC);
        $display("test special done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        {nrst, bgRequest, ssc, secured, eraseVerified} = '0;
        {lowTagN, highTagN} = 2'b11;
        lowStrobe = 1'b0;
        blockAddr = 4'ha;
        cpuCcr = 8'h3c;
        evt = '0;
        do_reset();
        t_map();
        t_write();
        t_active();
        t_tag();
        t_ssc();
        print_verdict();
    end
endmodule
`default_nettype wire
